// ### shared/isc_consts.svh
// isc_consts.svh: mode codes, bit positions and reset values of the
// two-wire port control block.
// assumes it is included by bare name wherever the values are needed.
`ifndef ISC_CONSTS_SVH
`define ISC_CONSTS_SVH

// ----------------------------------------------------------------------
// mode select codes
// ----------------------------------------------------------------------
`define ISC_MODE_SL7      4'h6
`define ISC_MODE_SL10     4'h7
`define ISC_MODE_MASTER   4'h8
`define ISC_MODE_SL7_SP   4'he
`define ISC_MODE_SL10_SP  4'hf
`define ISC_MODE_TEN_BIT  0
`define ISC_MODE_SP_BIT   3

// ----------------------------------------------------------------------
// byte framing
// ----------------------------------------------------------------------
`define ISC_HI10_TAG      5'h1e
`define ISC_GEN_CALL      8'h00
`define ISC_BIT_EIGHTH    4'h7
`define ISC_BIT_NINTH     4'h8
`define ISC_CNT_ZERO      4'h0
`define ISC_CNT_STEP      4'h1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ISC_RST_BYTE      8'h00
`define ISC_RST_RELEASE   1'b1

`endif

// ### shared/isc_pkg.sv
// isc_pkg: types shared by the port control core and its bench.
// assumes nothing beyond a SystemVerilog compiler.
package isc_pkg;

  typedef logic [7:0] isc_byte_t;
  typedef logic [3:0] isc_mode_t;

  typedef enum logic [2:0] {
    st_idle  = 3'b000,
    st_addr1 = 3'b001,
    st_addr2 = 3'b010,
    st_rx    = 3'b011,
    st_tx    = 3'b100
  } isc_phase_t;

endpackage

// ### shared/isc_link_if.sv
// isc_link_if: levels and hold requests between core and pin stage.
// assumes the receiving side of each signal synchronises it.
`timescale 1ns/10ps
interface isc_link_if;
  logic scl_lvl;
  logic sda_lvl;
  logic scl_hold;
  logic sda_hold;

  modport core (input scl_lvl, input sda_lvl,
                output scl_hold, output sda_hold);
  modport pin  (output scl_lvl, output sda_lvl,
                input scl_hold, input sda_hold);
endinterface

// ### rtl/isc_pin.sv
// isc_pin: open-drain pin stage on the link clock.
// assumes the core hold requests are levels from another clock domain.
`timescale 1ns/10ps
module isc_pin (
  input  wire logic i_link_clk,
  input  wire logic i_rst_n,
  input  wire logic i_scl_in,
  input  wire logic i_sda_in,
  output logic      o_scl_out,
  output logic      o_scl_oe,
  output logic      o_sda_out,
  output logic      o_sda_oe,
  isc_link_if.pin   lnk
);
  logic rst_m, rst_s;
  logic scl_m, scl_s, sda_m, sda_s;
  logic shold_m, shold_s, dhold_m, dhold_s;

  // ----------------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------------
  // reset is a core-domain level, so it is brought over like any other
  always_ff @(posedge i_link_clk) begin
    rst_m <= i_rst_n;
    rst_s <= rst_m;
  end

  always_ff @(posedge i_link_clk) begin
    if (!rst_s) begin
      scl_m   <= 1'b1;
      scl_s   <= 1'b1;
      sda_m   <= 1'b1;
      sda_s   <= 1'b1;
      shold_m <= 1'b0;
      shold_s <= 1'b0;
      dhold_m <= 1'b0;
      dhold_s <= 1'b0;
    end else begin
      scl_m   <= i_scl_in;
      scl_s   <= scl_m;
      sda_m   <= i_sda_in;
      sda_s   <= sda_m;
      shold_m <= lnk.scl_hold;
      shold_s <= shold_m;
      dhold_m <= lnk.sda_hold;
      dhold_s <= dhold_m;
    end
  end

  assign lnk.scl_lvl = scl_s;
  assign lnk.sda_lvl = sda_s;

  // ----------------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_link_clk) begin
    if (!rst_s) begin
      o_scl_oe  <= 1'b0;
      o_sda_oe  <= 1'b0;
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
    end else begin
      o_scl_oe  <= shold_s && (o_scl_oe || !scl_s);
      o_sda_oe  <= dhold_s;
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
    end
  end
endmodule

// ### rtl/isc_ctl.sv
// isc_ctl: two-wire port control: slave clock stretching, general call,
// master start and the serial interrupt flag.
// assumes software strobes are one-cycle pulses on i_core_clk and the
// bus pins are open drain with external pull-ups.
//
// Behaviour
// - full buffer at ninth fall clears release
// - release bit low keeps clock held
// - early buffer read means no stretch
// - software may set release bit anytime
// - 10-bit address bytes stretch on update flag
// - update flag after high, low address bytes
// - address register write frees held clock
// - buffer-full stretch on data bytes only
// - transmit: empty buffer at ninth fall stretches
// - early buffer load means no transmit stretch
// - 10-bit read address then follows buffer flag
// - pull clock only after seeing it low
// - clock stays low until all release
// - general call is zero byte, write
// - general call compared beside own address
// - general call loads buffer, flag at ninth
// - 10-bit general call skips second byte
// - start, stop flags cleared when disabled
// - buffer write during pending start collides
// - master flags start, stop, bytes, acks
// - master mode via mode bits, enable
// - stretch enable adds receive stretching
// - buffer read clears full; overflow by software
`timescale 1ns/10ps
`include "isc_consts.svh"
module isc_ctl (
  input  wire logic               i_core_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_clk_en,
  input  wire logic               i_link_clk,
  input  wire logic               i_scl_in,
  input  wire logic               i_sda_in,
  output logic                    o_scl_out,
  output logic                    o_scl_oe,
  output logic                    o_sda_out,
  output logic                    o_sda_oe,
  input  wire logic               i_port_enable,
  input  wire isc_pkg::isc_mode_t i_mode_select,
  input  wire logic               i_stretch_enable,
  input  wire logic               i_general_call_enable,
  input  wire logic               i_buf_rd,
  input  wire logic               i_buf_wr,
  input  wire isc_pkg::isc_byte_t i_buf_wdata,
  input  wire logic               i_addr_wr,
  input  wire isc_pkg::isc_byte_t i_addr_wdata,
  input  wire logic               i_ckp_set,
  input  wire logic               i_start_req,
  input  wire logic               i_ovf_clr,
  input  wire logic               i_irq_clr,
  input  wire logic               i_write_collision_flag_clr,
  output isc_pkg::isc_byte_t      o_xfer_buffer,
  output isc_pkg::isc_byte_t      o_slave_addr,
  output logic                    o_buffer_full,
  output logic                    o_clock_release,
  output logic                    o_update_address,
  output logic                    o_serial_irq,
  output logic                    o_write_collision,
  output logic                    o_receive_overflow,
  output logic                    o_start_seen,
  output logic                    o_stop_seen,
  output logic                    o_read_not_write,
  output logic                    o_start_pending
);
  import isc_pkg::*;

  logic       slv, ten, sp_irq, mst;
  logic       scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic       ev_rise, ev_fall, ev_start, ev_stop, f8, f9;
  isc_phase_t ph_q, ph_d;
  logic [3:0] cnt_q;
  isc_byte_t  sh_q, buf_q, addr_q;
  logic       bf_q, ckp_q, ua_q, uah_q, ovf_q, irq_q, write_collision_flag_q;
  logic       ss_q, ps_q, rw_q, sp_q, own_q, hi_ok_q, sf_q;
  logic       ack_q, b_addr_q, b_irq_q, scl_hold_q, sda_hold_q;
  logic       acc, ua_set, gc, busy, ack_d, ld_buf;
  logic       wr_ok, tx_copy, rx_str, tx_str, ckp_clr, tx_low;

  isc_link_if lnk ();

  isc_pin u_pin (
    .i_link_clk (i_link_clk),
    .i_rst_n    (i_rst_n),
    .i_scl_in   (i_scl_in),
    .i_sda_in   (i_sda_in),
    .o_scl_out  (o_scl_out),
    .o_scl_oe   (o_scl_oe),
    .o_sda_out  (o_sda_out),
    .o_sda_oe   (o_sda_oe),
    .lnk        (lnk.pin)
  );

  function automatic logic addr_hit(input isc_byte_t sh,
                                    input isc_byte_t ad);
    addr_hit = (sh[7:1] == ad[7:1]);
  endfunction

  // ----------------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------------
  // mode bits with enable
  assign mst = i_port_enable && (i_mode_select == `ISC_MODE_MASTER);
  assign slv = i_port_enable &&
               ((i_mode_select == `ISC_MODE_SL7) ||
                (i_mode_select == `ISC_MODE_SL10) ||
                (i_mode_select == `ISC_MODE_SL7_SP) ||
                (i_mode_select == `ISC_MODE_SL10_SP));
  assign ten    = slv && i_mode_select[`ISC_MODE_TEN_BIT];
  assign sp_irq = slv && i_mode_select[`ISC_MODE_SP_BIT];

  // ----------------------------------------------------------------------
  // bus sampling and events
  // ----------------------------------------------------------------------
  // second sync into core
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else if (i_clk_en) begin
      scl_m <= lnk.scl_lvl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= lnk.sda_lvl;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  assign ev_rise  = scl_s && !scl_d;
  assign ev_fall  = !scl_s && scl_d;
  assign ev_start = scl_s && scl_d && sda_d && !sda_s;
  assign ev_stop  = scl_s && scl_d && !sda_d && sda_s;
  assign f8       = ev_fall && (cnt_q == `ISC_BIT_EIGHTH);
  assign f9       = ev_fall && (cnt_q == `ISC_BIT_NINTH);

  // ----------------------------------------------------------------------
  // address decision at the eighth falling edge
  // ----------------------------------------------------------------------
  always_comb begin
    acc    = 1'b0;
    ua_set = 1'b0;
    ph_d   = ph_q;
    gc     = i_general_call_enable && (sh_q == `ISC_GEN_CALL);
    busy   = bf_q || ovf_q;
    case (ph_q)
      st_addr1: begin
        if (gc) begin
          acc  = 1'b1;
          ph_d = st_rx;
        end else if (ten && (sh_q[7:3] == `ISC_HI10_TAG) &&
                     addr_hit(sh_q, addr_q)) begin
          acc = 1'b1;
          if (!sh_q[0]) begin
            ua_set = 1'b1;
            ph_d   = st_addr2;
          end else if (hi_ok_q) begin
            ph_d = st_tx;
          end else begin
            acc  = 1'b0;
            ph_d = st_idle;
          end
        end else if (!ten && addr_hit(sh_q, addr_q)) begin
          acc  = 1'b1;
          ph_d = sh_q[0] ? st_tx : st_rx;
        end else begin
          ph_d = st_idle;
        end
      end
      st_addr2: begin
        if (sh_q == addr_q) begin
          acc    = 1'b1;
          ua_set = 1'b1;
          ph_d   = st_rx;
        end else begin
          ph_d = st_idle;
        end
      end
      st_rx:   acc = 1'b1;
      default: acc = 1'b0;
    endcase
  end

  // an accepted read address gets its ack even when busy; a full buffer there is tx data
  assign ack_d  = acc && ((ph_d == st_tx) || !busy);
  assign ld_buf = f8 && ack_d && (ph_d != st_tx);

  // ----------------------------------------------------------------------
  // phase and bit counter
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ph_q  <= st_idle;
      cnt_q <= `ISC_CNT_ZERO;
      sf_q  <= 1'b0;
    end else if (i_clk_en) begin
      if (!slv && !mst) begin
        ph_q  <= st_idle;
        cnt_q <= `ISC_CNT_ZERO;
        sf_q  <= 1'b0;
      end else if (ev_start) begin
        ph_q  <= slv ? st_addr1 : st_idle;
        cnt_q <= `ISC_CNT_ZERO;
        sf_q  <= 1'b1;
      end else if (ev_stop) begin
        ph_q  <= st_idle;
        cnt_q <= `ISC_CNT_ZERO;
      end else begin
        // the clock fall that closes a start is no bit of the byte
        if (ev_fall && sf_q) begin
          sf_q <= 1'b0;
        end else if (ev_fall) begin
          cnt_q <= (cnt_q == `ISC_BIT_NINTH) ? `ISC_CNT_ZERO
                                             : cnt_q + `ISC_CNT_STEP;
        end
        if (f8) begin
          ph_q <= ph_d;
        end else if (ev_rise && (ph_q == st_tx) &&
                     (cnt_q == `ISC_BIT_NINTH) && sda_s) begin
          // master refused the byte: transmit is over
          ph_q <= st_idle;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // shift register, buffer and address register
  // ----------------------------------------------------------------------
  // no queued buffer write
  assign wr_ok   = i_buf_wr && !(mst && sp_q);
  // copying only between bytes keeps a bit on the wire from changing
  assign tx_copy = wr_ok && (ph_q == st_tx) &&
                   (((cnt_q == `ISC_CNT_ZERO) && !scl_s) ||
                    (cnt_q == `ISC_BIT_NINTH));

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      sh_q <= `ISC_RST_BYTE;
    end else if (i_clk_en) begin
      if (tx_copy) begin
        sh_q <= i_buf_wdata;
      end else if (f8 && (ph_d == st_tx) && (ph_q != st_tx)) begin
        sh_q <= buf_q;
      end else if (ph_q == st_tx) begin
        if (ev_fall && (cnt_q < `ISC_BIT_EIGHTH)) begin
          sh_q <= {sh_q[6:0], 1'b1};
        end
      end else if (ev_rise) begin
        sh_q <= {sh_q[6:0], sda_s};
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      buf_q  <= `ISC_RST_BYTE;
      addr_q <= `ISC_RST_BYTE;
    end else if (i_clk_en) begin
      if (ld_buf) begin
        buf_q <= sh_q;
      end else if (wr_ok) begin
        buf_q <= i_buf_wdata;
      end
      if (i_addr_wr) begin
        addr_q <= i_addr_wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // buffer, overflow and address flags
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      bf_q    <= 1'b0;
      ovf_q   <= 1'b0;
      ua_q    <= 1'b0;
      rw_q    <= 1'b0;
      hi_ok_q <= 1'b0;
    end else if (i_clk_en) begin
      if (ld_buf || wr_ok) begin
        bf_q <= 1'b1;
      end else if (i_buf_rd || (f8 && (ph_q == st_tx))) begin
        bf_q <= 1'b0;
      end
      if (f8 && acc && !ack_d) begin
        ovf_q <= 1'b1;
      end else if (i_ovf_clr) begin
        ovf_q <= 1'b0;
      end
      if (f8 && ua_set) begin
        ua_q <= 1'b1;
      end else if (i_addr_wr || !slv) begin
        ua_q <= 1'b0;
      end
      if (f8 && acc && (ph_q != st_rx)) begin
        rw_q <= (ph_d == st_tx);
      end
      if (f8 && acc && (ph_q == st_addr2)) begin
        hi_ok_q <= 1'b1;
      end else if (ev_stop || !slv) begin
        hi_ok_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // acknowledge and ninth-clock bookkeeping
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ack_q    <= 1'b0;
      b_addr_q <= 1'b0;
      b_irq_q  <= 1'b0;
    end else if (i_clk_en) begin
      if (f8) begin
        ack_q    <= ack_d && slv;
        b_addr_q <= (ph_q == st_addr1) || (ph_q == st_addr2);
        b_irq_q  <= acc || (ph_q == st_tx);
      end else if (f9 || ev_start || ev_stop) begin
        ack_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // clock stretching
  // ----------------------------------------------------------------------
  // data receive only
  assign rx_str  = (ph_q == st_rx) && !b_addr_q &&
                   i_stretch_enable && bf_q;
  assign tx_str  = (ph_q == st_tx) && !bf_q;
  assign ckp_clr = slv && f9 && (rx_str || tx_str);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ckp_q <= `ISC_RST_RELEASE;
      uah_q <= 1'b0;
    end else if (i_clk_en) begin
      if (i_ckp_set) begin
        ckp_q <= 1'b1;
      end else if (ckp_clr) begin
        ckp_q <= 1'b0;
      end
      if (!slv) begin
        uah_q <= 1'b0;
      end else if (f9 && b_addr_q && ua_q) begin
        uah_q <= 1'b1;
      end else if (i_addr_wr) begin
        uah_q <= 1'b0;
      end
    end
  end

  // every data bit slot of the byte, the acknowledge slot excluded: cnt_q is 8 there
  assign tx_low = (ph_q == st_tx) && (cnt_q < `ISC_BIT_NINTH) && !sh_q[7];

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      scl_hold_q <= 1'b0;
      sda_hold_q <= 1'b0;
    end else if (i_clk_en) begin
      scl_hold_q <= slv && (!ckp_q || uah_q);
      sda_hold_q <= (slv && (ack_q || tx_low)) || sp_q || own_q;
    end
  end

  assign lnk.scl_hold = scl_hold_q;
  assign lnk.sda_hold = sda_hold_q;

  // ----------------------------------------------------------------------
  // bus state, master start and interrupt flag
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ss_q <= 1'b0;
      ps_q <= 1'b0;
    end else if (i_clk_en) begin
      if (!i_port_enable) begin
        ss_q <= 1'b0;
        ps_q <= 1'b0;
      end else if (ev_start) begin
        ss_q <= 1'b1;
        ps_q <= 1'b0;
      end else if (ev_stop) begin
        ss_q <= 1'b0;
        ps_q <= 1'b1;
      end
    end
  end

  // the owned bus keeps SDA low until master mode is left
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      sp_q  <= 1'b0;
      own_q <= 1'b0;
    end else if (i_clk_en) begin
      if (!mst) begin
        sp_q  <= 1'b0;
        own_q <= 1'b0;
      end else if (sp_q && ev_start) begin
        sp_q  <= 1'b0;
        own_q <= 1'b1;
      end else if (i_start_req && !sp_q && !own_q &&
                   (ps_q || !ss_q) && scl_s && sda_s) begin
        // start only on a free bus
        sp_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      irq_q  <= 1'b0;
      write_collision_flag_q <= 1'b0;
    end else if (i_clk_en) begin
      if ((slv && f9 && b_irq_q) ||
          (sp_irq && (ev_start || ev_stop)) ||
          (mst && (ev_start || ev_stop || f9))) begin
        irq_q <= 1'b1;
      end else if (i_irq_clr) begin
        irq_q <= 1'b0;
      end
      if (i_buf_wr && mst && sp_q) begin
        write_collision_flag_q <= 1'b1;
      end else if (i_write_collision_flag_clr) begin
        write_collision_flag_q <= 1'b0;
      end
    end
  end

  assign o_xfer_buffer      = buf_q;
  assign o_slave_addr       = addr_q;
  assign o_buffer_full      = bf_q;
  assign o_clock_release    = ckp_q;
  assign o_update_address   = ua_q;
  assign o_serial_irq       = irq_q;
  assign o_write_collision  = write_collision_flag_q;
  assign o_receive_overflow = ovf_q;
  assign o_start_seen       = ss_q;
  assign o_stop_seen        = ps_q;
  assign o_read_not_write   = rw_q;
  assign o_start_pending    = sp_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_rx_stretch: assert property (
    i_clk_en && slv && f9 && (ph_q == st_rx) && !b_addr_q &&
    i_stretch_enable && bf_q && !i_ckp_set |=> !ckp_q)
    else $error("receive stretch did not clear release bit");
  a_hold_low: assert property (
    i_clk_en && slv && !ckp_q |=> scl_hold_q)
    else $error("clock not held while release bit low");
  a_rx_no_stretch: assert property (
    i_clk_en && f9 && (ph_q == st_rx) && !bf_q && ckp_q |=> ckp_q)
    else $error("stretch with empty receive buffer");
  a_ua_hold: assert property (
    i_clk_en && slv && f9 && b_addr_q && ua_q && !i_ckp_set
    |=> uah_q && $stable(ckp_q))
    else $error("address stretch wrong");
  a_ua_free: assert property (
    i_clk_en && slv && i_addr_wr && !f8 && !f9
    |=> !uah_q && !ua_q ##1 (!scl_hold_q || !ckp_q || !i_clk_en))
    else $error("address write did not free clock");
  a_tx_stretch: assert property (
    i_clk_en && slv && f9 && (ph_q == st_tx) && !bf_q && !i_ckp_set
    |=> !ckp_q)
    else $error("transmit stretch missing");
  a_gc_load: assert property (
    i_clk_en && slv && f8 && (ph_q == st_addr1) &&
    i_general_call_enable && (sh_q == `ISC_GEN_CALL) && !bf_q && !ovf_q
    |=> bf_q && (buf_q == `ISC_GEN_CALL) && (ph_q == st_rx))
    else $error("general call not taken");
  a_flags_off: assert property (
    i_clk_en && !i_port_enable |=> !ss_q && !ps_q)
    else $error("start or stop flag survives disable");
  a_write_collision_flag_set: assert property (
    i_clk_en && mst && sp_q && i_buf_wr |=> write_collision_flag_q && $stable(buf_q))
    else $error("queued buffer write not refused");
  a_bf_read: assert property (
    i_clk_en && i_buf_rd && !i_buf_wr && !f8 |=> !bf_q)
    else $error("buffer read did not clear full flag");

  c_rx_stretch: cover property (i_clk_en && ckp_clr && rx_str);
  c_gen_call:   cover property (i_clk_en && f8 && gc && slv);
  c_ten_hold:   cover property (i_clk_en && uah_q && i_addr_wr);
  c_start_done: cover property (i_clk_en && sp_q && ev_start);
endmodule

// ### bench/isc_bus_model.sv
// isc_bus_model: behavioural bus master at the far side of the port.
// assumes pull-ups on both wires; the bench resolves all pull-downs.
`timescale 1ns/10ps
module isc_bus_model (
  input  wire logic i_scl,
  output logic      o_scl_low,
  output logic      o_sda_low
);
  initial idle();
  task automatic idle();
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  endtask
  task automatic start();
    #1200 o_sda_low = 1'b1;
    #1200 o_scl_low = 1'b1;
  endtask
  task automatic clk(input logic b);
    int n;
    #600 o_sda_low = ~b;
    #600 o_scl_low = 1'b0;
    for (n = 0; n < 99 && i_scl !== 1'b1; n++) #100;
    #1200 o_scl_low = 1'b1;
  endtask
  task automatic stop();
    #600 o_sda_low = 1'b1;
    #600 o_scl_low = 1'b0;
    #1200 o_sda_low = 1'b0;
  endtask
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) clk(b[i]);
  endtask
endmodule

// ### bench/tb_isc_ctl.sv
// tb_isc_ctl: self-checking bench of the port control block.
// assumes isc_bus_model as far-side master, pull-ups on both wires.
`timescale 1ns/10ps
module tb_isc_ctl;
  import isc_pkg::*;
  typedef struct packed {logic s, g, e, x; isc_byte_t a;} isc_row_t;
  logic      clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, en = 1'b1, ce = 1'b1;
  logic      stretch_enable_bit = 1'b0, gc = 1'b0, ms, md, scl_oe, sda_oe;
  logic      full, rel, ua, irq, write_collision_flag, ss, ps, pend;
  logic [7:0] stb = 8'h00;
  isc_mode_t mode = 4'h6;
  isc_byte_t wd = 8'h00, xb;
  isc_row_t  r;
  int        n, failures = 0, num_checks = 0;
  // stretch, gen call, early access, release expected, address
  isc_row_t  rows [6] = '{12'h8a0, 12'h1a0, 12'hba0, 12'h0a1, 12'h3a1,
                          12'hc00};
  wire scl = ~(ms | scl_oe);
  wire sda = ~(md | sda_oe);
  initial forever #20 clk = ~clk;
  initial begin
    #13;
    forever #40 lclk = ~lclk;
  end
  isc_bus_model isc_bus_model_i (.i_scl(scl), .o_scl_low(ms),
    .o_sda_low(md));
  isc_ctl isc_ctl_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_clk_en(ce),
    .i_link_clk(lclk), .i_scl_in(scl), .i_sda_in(sda), .o_scl_out(),
    .o_scl_oe(scl_oe), .o_sda_out(), .o_sda_oe(sda_oe),
    .i_port_enable(en), .i_mode_select(mode), .i_stretch_enable(stretch_enable_bit),
    .i_general_call_enable(gc), .i_buf_rd(stb[0]), .i_buf_wr(stb[1]),
    .i_buf_wdata(wd), .i_addr_wr(stb[2]), .i_addr_wdata(wd),
    .i_ckp_set(stb[3]), .i_start_req(stb[4]), .i_ovf_clr(stb[5]),
    .i_irq_clr(stb[6]), .i_write_collision_flag_clr(stb[7]), .o_xfer_buffer(xb),
    .o_slave_addr(), .o_buffer_full(full), .o_clock_release(rel),
    .o_update_address(ua), .o_serial_irq(irq), .o_write_collision(write_collision_flag),
    .o_receive_overflow(), .o_start_seen(ss), .o_stop_seen(ps),
    .o_read_not_write(), .o_start_pending(pend));
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input int k, input isc_byte_t d);
    @(posedge clk);
    stb[k] <= 1'b1;
    wd <= d;
    @(posedge clk);
    stb[k] <= 1'b0;
  endtask
  // reset held past three link edges so the pin stage sees it
  task automatic reset();
    isc_bus_model_i.idle();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    cyc(10);
  endtask
  task automatic chk1(input string s, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", s, e, g);
    end
  endtask
  task automatic chk8(input string s, input isc_byte_t e, isc_byte_t g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    reset();
    chk1("rst release", 1'b1, rel);
    chk1("rst seen", 1'b0, ss);
    foreach (rows[i]) begin
      r = rows[i];
      reset();
      @(posedge clk);
      stretch_enable_bit <= r.s;
      gc <= r.g;
      pulse(2, 8'ha0);
      cyc(4);
      isc_bus_model_i.start();
      isc_bus_model_i.send(r.a);
      if (!r.a[0]) begin
        isc_bus_model_i.clk(1'b1);
        cyc(40);
        chk8("addr byte", r.a, xb);
        pulse(0, wd);
        pulse(6, wd);
        isc_bus_model_i.send(8'hc5);
      end
      cyc(20);
      if (r.e) pulse(r.a[0], 8'h96);
      isc_bus_model_i.clk(1'b1);
      cyc(40);
      chk1("release", r.x, rel);
      chk1("irq", 1'b1, irq);
      chk1("scl hold", ~r.x, scl_oe);
      pulse(3, wd);
      cyc(40);
      chk1("scl free", 1'b0, scl_oe);
    end
    reset();
    @(posedge clk);
    mode <= 4'h7;
    pulse(2, 8'hf2);
    cyc(4);
    isc_bus_model_i.start();
    isc_bus_model_i.send(8'hf2);
    isc_bus_model_i.clk(1'b1);
    cyc(40);
    chk1("upd addr", 1'b1, ua);
    chk1("addr hold", 1'b1, scl_oe);
    chk1("rel kept", 1'b1, rel);
    pulse(2, 8'h34);
    cyc(40);
    chk1("addr free", 1'b0, scl_oe);
    isc_bus_model_i.stop();
    cyc(40);
    chk1("stop seen", 1'b1, ps);
    reset();
    @(posedge clk);
    mode <= 4'h8;
    pulse(4, wd);
    pulse(1, 8'h77);
    cyc(1);
    chk1("collision", 1'b1, write_collision_flag);
    chk8("buf kept", 8'h00, xb);
    chk1("start pend", 1'b1, pend);
    for (n = 0; n < 200 && irq !== 1'b1; n++) cyc(1);
    chk1("start irq", 1'b1, irq);
    chk1("pending", 1'b0, pend);
    chk1("sda held", 1'b1, sda_oe);
    @(posedge clk);
    ce <= 1'b0;
    en <= 1'b0;
    cyc(3);
    chk1("frozen seen", 1'b1, ss);
    @(posedge clk);
    ce <= 1'b1;
    cyc(3);
    chk1("seen clr", 1'b0, ss);
    results();
  end
endmodule
